// >>> design/crrs_pkg.sv
// constants for the cpu register set and status block
// assumes a single core clock and an apb register port

package crrs_pkg;

	// apb byte offsets of the block registers
	localparam logic [7:0] OFS_PSW    = 8'h00; // processor_status_word
	localparam logic [7:0] OFS_CFG    = 8'h04; // mode bits, short_register_mode
	localparam logic [7:0] OFS_PC     = 8'h08; // program_counter
	localparam logic [7:0] OFS_ISP    = 8'h0c; // exception_stack_pointer
	localparam logic [7:0] OFS_USP    = 8'h10; // user_stack_pointer
	localparam logic [7:0] OFS_BASE   = 8'h14; // dispatch_table_base
	localparam logic [7:0] OFS_STAT   = 8'h18; // read-only core state
	localparam logic [7:0] OFS_GPR    = 8'h40; // first of 16 gpr words
	localparam logic [7:0] OFS_GPR_END = 8'h7c; // last gpr word

	// status word bit positions
	localparam int PSW_C = 0;  // carry
	localparam int PSW_T = 1;  // trace
	localparam int PSW_L = 2;  // unsigned low
	localparam int PSW_U = 3;  // user mode
	localparam int PSW_F = 5;  // flag / overflow
	localparam int PSW_Z = 6;  // zero
	localparam int PSW_N = 7;  // negative
	localparam int PSW_E = 9;  // local interrupt enable
	localparam int PSW_P = 10; // trace pending
	localparam int PSW_I = 11; // global interrupt enable

	// config bit positions
	localparam int CFG_ED = 8; // extended dispatch
	localparam int SHORT_REGISTER_MODE = 9; // short_register_mode

	// reset values and masks
	localparam logic [15:0] PSW_RESET = 16'h0200; // only local enable set
	localparam logic [15:0] PSW_WMASK = 16'h0eef; // bits 4, 8, 15:12 stay zero
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] CFG_WMASK = 16'h0300;
	localparam logic [23:0] PC_PRESET = 24'h000000; // reset fetch address
	localparam logic [31:0] ISP_MASK  = 32'h00fffffe; // lsb and top byte zero
	localparam logic [31:0] USP_LIMIT = 32'h00ffffff; // highest legal address

	// gpr indices with a special role
	localparam logic [3:0] IDX_R0  = 4'h0;
	localparam logic [3:0] IDX_R1  = 4'h1;
	localparam logic [3:0] IDX_R2  = 4'h2;
	localparam logic [3:0] IDX_R11 = 4'hb; // last 16-bit register
	localparam logic [3:0] IDX_R13 = 4'hd;

	// operand size on the core ports
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_PAIR = 2'b10
	} crrs_size_t;

endpackage : crrs_pkg

// >>> design/crrs_regs.sv
// architectural register set, status word and apb access for the core
// assumes core strobes are one-cycle pulses synchronous to clk
//
// Functional notes
// - r0-r11 16 bit, r12-sp 32, pc 24
// - short mode pairs adjacent 16-bit low halves
// - native mode: r12, r13, ra, sp full
// - byte/word ops touch only the low part
// - pc lsb always zero
// - reset loads preset pc; warm saves to r1:r0
// - isp lsb and top byte forced zero
// - usp above 0x00ffffff on stack access in user mode traps
// - status bit layout, bits 4, 8 zero
// - carry set on carry or borrow
// - trace trap after instruction, not in handler
// - trace copied to pending at instruction start outside a handler, pending cleared inside
// - low and negative flag second below first
// - zero flag set on equal compare
// - user picks usp, exception enters supervisor
// - usp access in user mode traps
// - maskable irq needs local and global enable
// - enable/disable instructions set/clear local enable
// - global enable cleared on irq entry, set on return from an irq handler
// - status reset value; warm copies into r2
// - overflow in flag; bits change only explicitly

module crrs_regs
	import crrs_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        warm_reset,     // sync pulse, warm restart

	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,

	// gpr read port, registered
	input  wire logic [3:0]  rd_idx,
	input  wire logic [1:0]  rd_size,
	output logic [31:0]      rd_data,

	// gpr write port
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_idx,
	input  wire logic [1:0]  wr_size,
	input  wire logic [31:0] wr_data,

	// program counter
	input  wire logic        pc_we,
	input  wire logic [23:0] pc_next,
	output logic [23:0]      program_counter,

	// arithmetic flag update
	input  wire logic        arith_we,
	input  wire logic        arith_sub,
	input  wire logic [15:0] arith_a,
	input  wire logic [15:0] arith_b,

	// compare flag update
	input  wire logic        cmp_we,
	input  wire logic [15:0] cmp_first,
	input  wire logic [15:0] cmp_second,

	// instruction events
	input  wire logic        instr_start,
	input  wire logic        instr_done,
	input  wire logic        irq_on_instruction,
	input  wire logic        irq_off_instruction,
	input  wire logic        user_jump,
	input  wire logic        exc_enter,
	input  wire logic        exc_is_irq,
	input  wire logic        exc_return,

	// stack and processor register access
	input  wire logic        stack_access,
	input  wire logic        load_processor_reg_op,
	input  wire logic        lpr_usp_we,
	input  wire logic [31:0] lpr_data,
	output logic [31:0]      stack_pointer_sel,

	// interrupt requests
	input  wire logic        irq_request,
	input  wire logic        nmi_request,
	output logic             irq_accept,
	output logic             nmi_accept,

	// traps and state
	output logic             trace_trap,
	output logic             illegal_address_trap,
	output logic             undefined_op_trap,
	output logic [15:0]      processor_status_word,
	output logic             short_register_mode
);

	// storage
	logic [31:0] gpr_q [16];       // r0..r13, return_address_reg, stack_pointer
	logic [15:0] psw_q;            // processor_status_word
	logic [15:0] cfg_q;            // mode bits
	logic [23:0] pc_q;             // program_counter
	logic [31:0] isp_q;            // exception_stack_pointer
	logic [31:0] usp_q;            // user_stack_pointer
	logic [31:0] base_q;           // dispatch_table_base
	logic        in_handler_q;     // exception handler running
	logic        saved_user_q;     // mode to restore on return
	logic        irq_nest_q;       // handler entered by irq
	logic [31:0] rd_data_q;
	logic [31:0] sp_sel_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        trace_trap_q;
	logic        iad_trap_q;
	logic        und_trap_q;
	logic        irq_acc_q;
	logic        nmi_acc_q;

	// apb decode
	logic        apb_setup;        // first cycle of a transfer
	logic        apb_wr;           // write commits this edge
	logic        addr_ok;          // offset maps to a register
	logic        gpr_hit;          // offset in the gpr window
	logic [3:0]  gpr_sel;          // gpr index from offset
	logic [31:0] rd_mux;           // apb read value

	// core datapath helpers
	logic [3:0]  rd_idx_p1;
	logic [3:0]  wr_idx_p1;
	logic        rd_split;         // pair built from two registers
	logic        wr_split;
	logic [16:0] arith_res;        // result with carry/borrow
	logic        arith_ovf;

	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign gpr_hit   = (paddr >= OFS_GPR) && (paddr <= OFS_GPR_END);
	assign gpr_sel   = paddr[5:2];
	assign rd_idx_p1 = rd_idx + 4'h1;
	assign wr_idx_p1 = wr_idx + 4'h1;

	// pairs of two registers: below r12 always, r12/r13 only in short mode
	assign rd_split = (rd_idx <= IDX_R11) ||
	                  (cfg_q[SHORT_REGISTER_MODE] && rd_idx <= IDX_R13);
	assign wr_split = (wr_idx <= IDX_R11) ||
	                  (cfg_q[SHORT_REGISTER_MODE] && wr_idx <= IDX_R13);

	// add or subtract on 17 bits so the top bit is carry or borrow
	always_comb begin
		if (arith_sub) begin
			arith_res = {1'b0, arith_a} - {1'b0, arith_b};
			arith_ovf = (arith_a[15] != arith_b[15]) && (arith_res[15] != arith_a[15]);
		end else begin
			arith_res = {1'b0, arith_a} + {1'b0, arith_b};
			arith_ovf = (arith_a[15] == arith_b[15]) && (arith_res[15] != arith_a[15]);
		end
	end

	// offsets that answer without error
	always_comb begin
		case (paddr)
			OFS_PSW, OFS_CFG, OFS_PC, OFS_ISP,
			OFS_USP, OFS_BASE, OFS_STAT: addr_ok = 1'b1;
			default:                     addr_ok = gpr_hit && (paddr[1:0] == 2'b00);
		endcase
	end

	// apb read value, narrow registers zero-extended
	always_comb begin
		case (paddr)
			OFS_PSW:  rd_mux = {16'h0000, psw_q};
			OFS_CFG:  rd_mux = {16'h0000, cfg_q};
			OFS_PC:   rd_mux = {8'h00, pc_q};
			OFS_ISP:  rd_mux = isp_q;
			OFS_USP:  rd_mux = usp_q;
			OFS_BASE: rd_mux = base_q;
			OFS_STAT: rd_mux = {29'h0, irq_nest_q, saved_user_q, in_handler_q};
			default:  rd_mux = gpr_hit ? gpr_q[gpr_sel] : 32'h0;
		endcase
	end

	// apb answer: one wait-free access phase after setup
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= apb_setup;
			pslverr_q <= apb_setup & ~addr_ok; // unmapped offset
			if (apb_setup) begin
				prdata_q <= addr_ok ? rd_mux : 32'h0;
			end
		end
	end

	// general registers: warm reset, then core port, then apb
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 16; i++) begin
				gpr_q[i] <= 32'h0;
			end
		end else if (warm_reset) begin
			gpr_q[IDX_R0] <= {16'h0000, pc_q[15:0]};
			gpr_q[IDX_R1] <= {24'h000000, pc_q[23:16]};
			gpr_q[IDX_R2] <= {16'h0000, psw_q};
		end else if (wr_en) begin
			case (crrs_size_t'(wr_size))
				// low byte only, rest kept
				SZ_BYTE: gpr_q[wr_idx][7:0] <= wr_data[7:0];
				// low word only, upper half kept
				SZ_WORD: gpr_q[wr_idx][15:0] <= wr_data[15:0];
				SZ_PAIR: begin
					if (wr_split) begin
						gpr_q[wr_idx][15:0]    <= wr_data[15:0];
						gpr_q[wr_idx_p1][15:0] <= wr_data[31:16];
					end else begin
						gpr_q[wr_idx] <= wr_data;
					end
				end
				default: gpr_q[wr_idx] <= gpr_q[wr_idx];
			endcase
		end else if (apb_wr && gpr_hit) begin
			// r0..r11 hold only 16 bits
			if (gpr_sel <= IDX_R11) begin
				gpr_q[gpr_sel] <= {16'h0000, pwdata[15:0]};
			end else begin
				gpr_q[gpr_sel] <= pwdata;
			end
		end
	end

	// registered read port
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_q <= 32'h0;
		end else begin
			case (crrs_size_t'(rd_size))
				SZ_BYTE: rd_data_q <= {24'h000000, gpr_q[rd_idx][7:0]};
				SZ_WORD: rd_data_q <= {16'h0000, gpr_q[rd_idx][15:0]};
				SZ_PAIR: begin
					if (rd_split) begin
						rd_data_q <= {gpr_q[rd_idx_p1][15:0], gpr_q[rd_idx][15:0]};
					end else begin
						rd_data_q <= gpr_q[rd_idx];
					end
				end
				default: rd_data_q <= 32'h0;
			endcase
		end
	end

	// program counter, even aligned
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_q <= PC_PRESET;
		end else if (warm_reset) begin
			pc_q <= PC_PRESET;
		end else if (pc_we) begin
			pc_q <= {pc_next[23:1], 1'b0};
		end else if (apb_wr && paddr == OFS_PC) begin
			pc_q <= {pwdata[23:1], 1'b0};
		end
	end

	// configuration bits, cleared by either reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q <= CFG_RESET;
		end else if (warm_reset) begin
			cfg_q <= CFG_RESET;
		end else if (apb_wr && paddr == OFS_CFG) begin
			cfg_q <= pwdata[15:0] & CFG_WMASK;
		end
	end

	// exception stack pointer, masked on every load
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			isp_q <= 32'h0;
		end else if (apb_wr && paddr == OFS_ISP) begin
			isp_q <= pwdata & ISP_MASK;
		end
	end

	// dispatch base stored as written; software keeps top byte and lsb zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			base_q <= 32'h0;
		end else if (apb_wr && paddr == OFS_BASE) begin
			base_q <= pwdata;
		end
	end

	// user stack pointer: core load only from supervisor mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			usp_q <= 32'h0;
		end else if (lpr_usp_we && !psw_q[PSW_U]) begin
			usp_q <= lpr_data;
		end else if (apb_wr && paddr == OFS_USP) begin
			usp_q <= pwdata;
		end
	end

	// handler tracking for mode restore and trace suppression
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_handler_q <= 1'b0;
			saved_user_q <= 1'b0;
			irq_nest_q   <= 1'b0;
		end else if (warm_reset) begin
			in_handler_q <= 1'b0;
			saved_user_q <= 1'b0;
			irq_nest_q   <= 1'b0;
		end else if (exc_enter) begin
			// one level only; nesting overwrites the saved mode
			in_handler_q <= 1'b1;
			saved_user_q <= psw_q[PSW_U];
			irq_nest_q   <= exc_is_irq;
		end else if (exc_return) begin
			in_handler_q <= 1'b0;
			irq_nest_q   <= 1'b0;
		end
	end

	// status word: hardware events win over an apb write the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			psw_q <= PSW_RESET;
		end else if (warm_reset) begin
			psw_q <= PSW_RESET;
		end else begin
			// software image first, then events overlay it
			if (apb_wr && paddr == OFS_PSW) begin
				psw_q <= pwdata[15:0] & PSW_WMASK;
			end
			if (arith_we) begin
				psw_q[PSW_C] <= arith_res[16];
				psw_q[PSW_F] <= arith_ovf;
			end
			if (cmp_we) begin
				psw_q[PSW_L] <= cmp_second < cmp_first;
				psw_q[PSW_N] <= $signed(cmp_second) < $signed(cmp_first);
				psw_q[PSW_Z] <= cmp_second == cmp_first;
			end
			if (instr_start) begin
				psw_q[PSW_P] <= psw_q[PSW_T] & ~in_handler_q;
			end else if (instr_done) begin
				psw_q[PSW_P] <= 1'b0;
			end
			if (irq_on_instruction) begin
				psw_q[PSW_E] <= 1'b1;
			end else if (irq_off_instruction) begin
				psw_q[PSW_E] <= 1'b0;
			end
			if (exc_enter) begin
				psw_q[PSW_U] <= 1'b0;
				if (exc_is_irq) begin
					psw_q[PSW_I] <= 1'b0;
				end
			end else if (exc_return) begin
				psw_q[PSW_U] <= saved_user_q;
				if (irq_nest_q) begin
					psw_q[PSW_I] <= 1'b1;
				end
			end else if (user_jump) begin
				psw_q[PSW_U] <= 1'b1;
			end
		end
	end

	// traps, interrupt acceptance and stack pointer choice
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trace_trap_q <= 1'b0;
			iad_trap_q   <= 1'b0;
			und_trap_q   <= 1'b0;
			irq_acc_q    <= 1'b0;
			nmi_acc_q    <= 1'b0;
			sp_sel_q     <= 32'h0;
		end else begin
			// pending bit still set when the instruction ends
			trace_trap_q <= instr_done & psw_q[PSW_P] & ~in_handler_q;
			iad_trap_q   <= stack_access & psw_q[PSW_U] & (usp_q > USP_LIMIT);
			und_trap_q   <= load_processor_reg_op & psw_q[PSW_U];
			irq_acc_q    <= irq_request & psw_q[PSW_E] & psw_q[PSW_I];
			nmi_acc_q    <= nmi_request;
			sp_sel_q     <= psw_q[PSW_U] ? usp_q : gpr_q[4'hf];
		end
	end

	// outputs straight from flops
	assign prdata                = prdata_q;
	assign pready                = pready_q;
	assign pslverr               = pslverr_q;
	assign rd_data               = rd_data_q;
	assign program_counter       = pc_q;
	assign stack_pointer_sel     = sp_sel_q;
	assign irq_accept            = irq_acc_q;
	assign nmi_accept            = nmi_acc_q;
	assign trace_trap            = trace_trap_q;
	assign illegal_address_trap  = iad_trap_q;
	assign undefined_op_trap     = und_trap_q;
	assign processor_status_word = psw_q;
	assign short_register_mode   = cfg_q[SHORT_REGISTER_MODE];

endmodule // crrs_regs

// >>> dv/crrs_regs_sva.sv
// checker: timing relations at the crrs_regs ports
// assumes a bind to crrs_regs, one clock, async low reset
module crrs_regs_sva
	import crrs_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// core events
	input wire logic        irq_request,
	input wire logic        nmi_request,
	input wire logic        stack_access,
	input wire logic        load_processor_reg_op,
	input wire logic        irq_on_instruction,
	input wire logic        instr_done,
	input wire logic        exc_enter,
	input wire logic        exc_is_irq,
	// outputs watched
	input wire logic        irq_accept,
	input wire logic        nmi_accept,
	input wire logic        trace_trap,
	input wire logic        illegal_address_trap,
	input wire logic        undefined_op_trap,
	input wire logic [15:0] processor_status_word,
	input wire logic [23:0] program_counter
);
	// short alias for the status word
	wire logic [15:0] psw = processor_status_word;
	// one domain, so clock and disable are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_pc_even;
		program_counter[0] == 1'b0;
	endproperty
	a_pc_even: assert property (p_pc_even) else $error("pc odd");
	property p_rsvd;
		psw[4] == 1'b0 && psw[8] == 1'b0 && psw[15:12] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("psw fixed bit set");
	// first edge after reset sees a past from inside reset, hence the guard
	property p_irq;
		$past(reset_n) |-> irq_accept == $past(irq_request && psw[PSW_E] && psw[PSW_I]);
	endproperty
	a_irq: assert property (p_irq) else $error("irq accept wrong");
	property p_nmi;
		$past(reset_n) |-> nmi_accept == $past(nmi_request);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi accept wrong");
	property p_ill;
		illegal_address_trap |-> $past(stack_access && psw[PSW_U]);
	endproperty
	a_ill: assert property (p_ill) else $error("stray address trap");
	property p_und;
		$past(reset_n) |-> undefined_op_trap == $past(load_processor_reg_op && psw[PSW_U]);
	endproperty
	a_und: assert property (p_und) else $error("undefined trap wrong");
	property p_ei;
		irq_on_instruction |=> psw[PSW_E];
	endproperty
	a_ei: assert property (p_ei) else $error("local enable not set");
	property p_trc;
		trace_trap |-> $past(instr_done && psw[PSW_P]);
	endproperty
	a_trc: assert property (p_trc) else $error("trace trap without pending");
	property p_exc;
		exc_enter && exc_is_irq |=> !psw[PSW_I] && !psw[PSW_U];
	endproperty
	a_exc: assert property (p_exc) else $error("irq entry state wrong");
	c_irq: cover property (irq_accept);
	c_trc: cover property (trace_trap);
	c_ill: cover property (illegal_address_trap);
endmodule // crrs_regs_sva

// >>> dv/crrs_regs_bench.sv
// bench for crrs_regs: apb host plus core event strobes
// assumes crrs_pkg and the checker are compiled first
module crrs_regs_bench;
	import crrs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, wr_data = 32'h0, lpr_data = 32'h0;
	logic [3:0]  rd_idx = 4'h0, wr_idx = 4'h0;
	logic [1:0]  rd_size = 2'h0, wr_size = 2'h0;
	logic        wr_en = 1'b0, pc_we = 1'b0, arith_we = 1'b0, arith_sub = 1'b0;
	logic        cmp_we = 1'b0, exc_is_irq = 1'b0, irq_request = 1'b0, nmi_request = 1'b0;
	logic [23:0] pc_next = 24'h0;
	logic [15:0] arith_a = 16'h0, arith_b = 16'h0, cmp_first = 16'h0, cmp_second = 16'h0;
	logic [10:0] evs = 11'h0; // event strobes, one-hot except EV_LPR which sets two bits
	wire logic   warm_reset, instr_start, instr_done, irq_on_instruction;
	wire logic   irq_off_instruction, user_jump, exc_enter, exc_return;
	wire logic   stack_access, load_processor_reg_op, lpr_usp_we;
	logic [31:0] prdata, rd_data, stack_pointer_sel;
	logic        pready, pslverr, irq_accept, nmi_accept, short_register_mode;
	logic        trace_trap, illegal_address_trap, undefined_op_trap;
	logic [23:0] program_counter;
	logic [15:0] psw;
	int          n_errors = 0, n_tests = 0;
	localparam logic [10:0] EV_WARM = 11'h001, EV_START = 11'h002, EV_DONE = 11'h004;
	localparam logic [10:0] EV_ON = 11'h008, EV_OFF = 11'h010, EV_UJ = 11'h020;
	localparam logic [10:0] EV_ENT = 11'h040, EV_RET = 11'h080, EV_STK = 11'h100;
	localparam logic [10:0] EV_LPR = 11'h600; // access op with usp write
	assign {lpr_usp_we, load_processor_reg_op, stack_access, exc_return, exc_enter,
		user_jump, irq_off_instruction, irq_on_instruction, instr_done, instr_start,
		warm_reset} = evs;

	crrs_regs u_crrs_regs (
		.clk, .reset_n, .warm_reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rd_idx, .rd_size, .rd_data, .wr_en, .wr_idx,
		.wr_size, .wr_data, .pc_we, .pc_next, .program_counter, .arith_we,
		.arith_sub, .arith_a, .arith_b, .cmp_we, .cmp_first, .cmp_second,
		.instr_start, .instr_done, .irq_on_instruction, .irq_off_instruction,
		.user_jump, .exc_enter, .exc_is_irq, .exc_return, .stack_access,
		.load_processor_reg_op, .lpr_usp_we, .lpr_data, .stack_pointer_sel,
		.irq_request, .nmi_request, .irq_accept, .nmi_accept, .trace_trap,
		.illegal_address_trap, .undefined_op_trap, .short_register_mode,
		.processor_status_word(psw)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic nx(input int k = 1);
		repeat (k) @(posedge clk);
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic results();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// one apb transfer; waits for pready as long as it takes, the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		nx();
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		nx();
		penable <= 1'b1;
		n = 0;
		do begin
			nx();
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		chk("pready", 32'h1, pready);
		chk("apb access cycles", 32'h1, n);
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk($sformatf("reg %h", a), x & m, q & m);
	endtask

	// strobe held for exactly one sampling edge
	task automatic ev(input logic [10:0] v);
		nx();
		evs <= v;
		nx();
		evs <= 11'h0;
		#1;
	endtask

	task automatic cw(input logic [3:0] i, input logic [1:0] s, input logic [31:0] d);
		nx();
		wr_en <= 1'b1;
		wr_idx <= i;
		wr_size <= s;
		wr_data <= d;
		nx();
		wr_en <= 1'b0;
	endtask

	task automatic cr(input logic [3:0] i, input logic [1:0] s, input logic [31:0] x);
		nx();
		rd_idx <= i;
		rd_size <= s;
		nx();
		#1 chk("rd_data", x, rd_data);
	endtask

	task automatic ar(input logic s, input logic [15:0] a, b, input logic [1:0] fc);
		nx();
		arith_we <= 1'b1;
		arith_sub <= s;
		arith_a <= a;
		arith_b <= b;
		nx();
		arith_we <= 1'b0;
		#1 chk("f c", fc, {psw[PSW_F], psw[PSW_C]});
	endtask

	task automatic cp(input logic [15:0] f, s, input logic [2:0] lnz);
		nx();
		cmp_we <= 1'b1;
		cmp_first <= f;
		cmp_second <= s;
		nx();
		cmp_we <= 1'b0;
		#1 chk("l n z", lnz, {psw[PSW_L], psw[PSW_N], psw[PSW_Z]});
		chk("f c kept", 0, {psw[PSW_F], psw[PSW_C]});
	endtask

	task automatic t_base();
		#1 chk("psw", 32'h0200, psw);
		rd(OFS_CFG, 32'h0);
		wr(OFS_PSW, 32'hffffffff);
		rd(OFS_PSW, 32'h0eef);
		wr(OFS_PSW, 32'h0200);
		wr(OFS_ISP, 32'hffffffff);
		rd(OFS_ISP, 32'h00fffffe);
		wr(OFS_BASE, 32'h00abcd00);
		rd(OFS_BASE, 32'h00abcd00);
		nx();
		pc_we <= 1'b1;
		pc_next <= 24'h123457;
		nx();
		pc_we <= 1'b0;
		#1 chk("pc", 32'h123456, program_counter);
		wr(OFS_PSW, 32'h0241);
		ev(EV_WARM);
		chk("pc warm", 0, program_counter);
		chk("psw warm", 32'h0200, psw);
		rd(OFS_GPR, 32'h3456);
		rd(OFS_GPR + 8'h04, 32'h0012);
		rd(OFS_GPR + 8'h08, 32'h0241);
		$display("base done");
	endtask

	task automatic t_pairs();
		wr(OFS_GPR + 8'h14, 32'hffffffff);
		rd(OFS_GPR + 8'h14, 32'h0000ffff);
		cw(4'h3, SZ_PAIR, 32'h12345678);
		cr(4'h3, SZ_PAIR, 32'h12345678);
		rd(OFS_GPR + 8'h0c, 32'h5678);
		rd(OFS_GPR + 8'h10, 32'h1234);
		cw(4'h3, SZ_BYTE, 32'hffffffaa);
		rd(OFS_GPR + 8'h0c, 32'h56aa);
		cw(4'h3, SZ_WORD, 32'hffffbeef);
		cr(4'h3, SZ_PAIR, 32'h1234beef);
		cw(4'hc, SZ_PAIR, 32'h11112222);
		rd(OFS_GPR + 8'h30, 32'h11112222);
		cw(4'hb, SZ_PAIR, 32'haaaa5555);
		rd(OFS_GPR + 8'h30, 32'haaaa, 32'hffff);
		wr(OFS_CFG, 32'h0200);
		chk("short", 1, short_register_mode);
		cw(4'hc, SZ_PAIR, 32'hcafe0bad);
		rd(OFS_GPR + 8'h30, 32'h0bad, 32'hffff);
		rd(OFS_GPR + 8'h34, 32'hcafe, 32'hffff);
		wr(OFS_CFG, 32'h0);
		$display("pairs done");
	endtask

	task automatic t_flags();
		ar(1'b0, 16'hffff, 16'h0001, 2'b01);
		ar(1'b0, 16'h7fff, 16'h0001, 2'b10);
		ar(1'b1, 16'h0000, 16'h0001, 2'b01);
		ar(1'b1, 16'h8000, 16'h0001, 2'b10);
		ar(1'b0, 16'h0005, 16'h0003, 2'b00);
		cp(16'h0005, 16'h0003, 3'b110);
		cp(16'h0001, 16'hffff, 3'b010);
		cp(16'hffff, 16'h0001, 3'b100);
		cp(16'h0007, 16'h0007, 3'b001);
		$display("flags done");
	endtask

	task automatic t_irq();
		nx();
		irq_request <= 1'b1;
		nmi_request <= 1'b1;
		exc_is_irq <= 1'b1;
		nx(2);
		#1 chk("irq", 0, irq_accept);
		chk("nmi", 1, nmi_accept);
		wr(OFS_PSW, 32'h0a00);
		nx();
		#1 chk("irq", 1, irq_accept);
		ev(EV_OFF);
		nx();
		#1 chk("irq", 0, irq_accept);
		ev(EV_ON);
		chk("e", 1, psw[PSW_E]);
		ev(EV_ENT);
		chk("i", 0, psw[PSW_I]);
		ev(EV_RET);
		chk("i", 1, psw[PSW_I]);
		nx();
		irq_request <= 1'b0;
		nmi_request <= 1'b0;
		exc_is_irq <= 1'b0;
		$display("irq done");
	endtask

	task automatic t_trace();
		wr(OFS_PSW, 32'h0202);
		ev(EV_START);
		chk("p", 1, psw[PSW_P]);
		ev(EV_DONE);
		chk("trace", 1, trace_trap);
		ev(EV_ENT);
		ev(EV_START);
		chk("p", 0, psw[PSW_P]);
		ev(EV_DONE);
		chk("trace", 0, trace_trap);
		ev(EV_RET);
		wr(OFS_PSW, 32'h0200);
		$display("trace done");
	endtask

	task automatic t_user();
		logic [31:0] q;
		logic        e;
		nx();
		lpr_data <= 32'h00ffffff;
		wr(OFS_USP, 32'h01000000);
		ev(EV_UJ);
		chk("u", 1, psw[PSW_U]);
		nx();
		#1 chk("sp", 32'h01000000, stack_pointer_sel);
		ev(EV_STK);
		chk("iad", 1, illegal_address_trap);
		ev(EV_LPR);
		chk("und", 1, undefined_op_trap);
		rd(OFS_USP, 32'h01000000);
		ev(EV_ENT);
		chk("u", 0, psw[PSW_U]);
		nx();
		#1 chk("sp sup", 32'h0, stack_pointer_sel);
		ev(EV_LPR);
		chk("und", 0, undefined_op_trap);
		rd(OFS_USP, 32'h00ffffff);
		ev(EV_RET);
		ev(EV_STK);
		chk("iad", 0, illegal_address_trap);
		ev(EV_WARM);
		apb(1'b0, 8'h20, 32'h0, q, e);
		chk("slverr", 1, e);
		chk("err data", 0, q);
		$display("user done");
	endtask

	initial begin
		nx(10);
		reset_n <= 1'b1;
		t_base();
		t_pairs();
		t_flags();
		t_irq();
		t_trace();
		t_user();
		results();
	end

	// cut a hang short; the run needs well under a thousand cycles
	initial begin
		#200000;
		n_errors++;
		$display("[ERR] watchdog exp done got hang");
		results();
	end
endmodule // crrs_regs_bench

bind crrs_regs crrs_regs_sva u_crrs_regs_sva (
	.clk, .reset_n, .irq_request, .nmi_request, .stack_access,
	.load_processor_reg_op, .irq_on_instruction, .instr_done, .exc_enter,
	.exc_is_irq, .irq_accept, .nmi_accept, .trace_trap, .illegal_address_trap,
	.undefined_op_trap, .processor_status_word, .program_counter
);
